// *** hw/scf_fifo.sv ***
`timescale 1ns/1ps

// Depth must be a power of two; pointers wrap naturally
module scf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// ==========================================================
	// Handshakes
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = mem_reg[rd_ptr_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage has no reset; only count decides what is valid
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// Pointers and fill level
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// *** hw/scf_pkg.sv ***
package scf_pkg;

	// ==========================================================
	// Clock, widths and depths
	localparam int CLK_HZ     = 20_000_000;
	localparam int WORD_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int DIV_W      = 7;
	localparam int CNT_W      = 8;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CFG    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DIV    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int CTRL_MASTER_BIT = 2;
	localparam int CTRL_PHASE_BIT  = 3;
	localparam int CFG_POL_BIT     = 6;
	localparam int ST_BUSY_BIT     = 0;
	localparam int ST_FULL_BIT     = 1;
	localparam int ST_EMPTY_BIT    = 2;
	localparam int ST_RXV_BIT      = 3;
	localparam int ST_OVR_BIT      = 4;
	localparam int ST_RATE_BIT     = 5;

	// ==========================================================
	// Rate derivation and limits
	localparam logic [DIV_W-1:0] DIV_SMALL   = 7'h03;
	localparam logic [CNT_W-1:0] RATIO_FIXED = 8'h04;
	localparam logic [3:0]       LAST_EDGE   = 4'hf;
	localparam logic [3:0]       LAST_BIT    = 4'h7;
	localparam logic [3:0]       WORD_BITS   = 4'h8;
	localparam int MAX_TX_HZ    = 25_000_000;
	localparam int MAX_RX_HZ    = 12_500_000;
	localparam int MIN_RATIO_TX = (CLK_HZ + MAX_TX_HZ - 1) / MAX_TX_HZ;
	localparam int MIN_RATIO_RX = (CLK_HZ + MAX_RX_HZ - 1) / MAX_RX_HZ;

	// ==========================================================
	// Types
	typedef struct packed {
		logic             master;
		logic             phase;
		logic             polarity;
		logic [DIV_W-1:0] divisor;
	} scf_cfg_t;

	typedef struct packed {
		logic sclk;
		logic sel_n;
		logic miso;
		logic mosi;
	} scf_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_SHIFT = 2'b10,
		ST_TRAIL = 2'b11
	} scf_state_t;

	// ==========================================================
	// Reset values
	localparam scf_cfg_t  CFG_RST  = '0;
	localparam scf_pins_t PINS_RST = 4'b0100;

	// ==========================================================
	// Shift clock ratio and its two phases
	function automatic logic [CNT_W-1:0] ratio_f(input logic [DIV_W-1:0] d);
		if (d < DIV_SMALL)
			return RATIO_FIXED;
		return CNT_W'(d) + 8'h01;
	endfunction

	function automatic logic [CNT_W-1:0] short_f(input logic [DIV_W-1:0] d);
		return ratio_f(d) >> 1;
	endfunction

	function automatic logic [CNT_W-1:0] long_f(input logic [DIV_W-1:0] d);
		return ratio_f(d) - short_f(d);
	endfunction

endpackage

// *** hw/scf_spi_top.sv ***
`timescale 1ns/1ps

module scf_spi_top
	import scf_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0]      prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Shift clock pin
	input  wire logic              shift_clock_i,
	output logic                   shift_clock_o,
	output logic                   shift_clock_oe,
	// Select pin, active low
	input  wire logic              select_n_i,
	output logic                   select_n_o,
	output logic                   select_n_oe,
	// Master-out data pin
	input  wire logic              master_out_line_i,
	output logic                   master_out_line_o,
	output logic                   master_out_line_oe,
	// Master-in data pin
	input  wire logic              master_in_line_i,
	output logic                   master_in_line_o,
	output logic                   master_in_line_oe
);
	scf_cfg_t          cfg_reg;
	scf_state_t        state_reg;
	scf_pins_t         sync1_reg, sync2_reg, sync3_reg, flt_reg, flt;
	logic [3:0]        agree;
	logic [CNT_W-1:0]  half_reg, short_len, long_len;
	logic [3:0]        edge_reg, bit_cnt_reg;
	logic              sclk_reg, select_n_reg, loaded_reg;
	logic              sclk_oe_reg, sel_oe_reg, miso_oe_reg;
	logic [WORD_W-1:0] tx_sh_reg, rx_sh_reg, rx_data_reg, tx_data, tx_word;
	logic              rx_valid_reg, overrun_reg, tx_valid, tx_in_ready;
	logic              pready_reg, pslverr_reg;
	logic [DATA_W-1:0] prdata_reg, rd_mux;
	logic              req, tx_wr, acc, push;
	logic              m_tick, m_lead, m_trail, m_finish, m_load;
	logic              s_act, s_chg, s_lead, s_trail, s_load;
	logic              lead_ev, trail_ev, rx_ev, sh_ev, load, pop, din;

	// ==========================================================
	// Pin synchronisers
	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= PINS_RST;
			sync2_reg <= PINS_RST;
			sync3_reg <= PINS_RST;
			flt_reg   <= PINS_RST;
		end
		else
		begin
			sync1_reg <= '{shift_clock_i, select_n_i, master_in_line_i, master_out_line_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			flt_reg   <= flt;
		end
	end
	// No fourth stage: a fourth flop would cost receive margin at ratio eight
	assign agree = ~(sync2_reg ^ sync3_reg);
	assign flt   = scf_pins_t'((flt_reg & ~agree) | (sync3_reg & agree));

	// ==========================================================
	// Edge decoding
	// Phase lengths; software keeps the ratio within rate limits
	assign short_len = short_f(cfg_reg.divisor);
	assign long_len  = long_f(cfg_reg.divisor);
	assign m_tick  = cfg_reg.master && (state_reg == ST_LEAD || state_reg == ST_SHIFT)
	                 && (half_reg == '0);
	assign m_lead  = m_tick && (sclk_reg == cfg_reg.polarity);
	assign m_trail = m_tick && (sclk_reg != cfg_reg.polarity);
	// Slave edges only count while the far master holds select low
	assign s_act   = !cfg_reg.master && !flt.sel_n;
	assign s_chg   = s_act && (flt.sclk != flt_reg.sclk);
	assign s_lead  = s_chg && (flt_reg.sclk == cfg_reg.polarity);
	assign s_trail = s_chg && (flt_reg.sclk != cfg_reg.polarity);
	assign lead_ev  = cfg_reg.master ? m_lead : s_lead;
	assign trail_ev = cfg_reg.master ? m_trail : s_trail;
	// Delayed phase samples on trailing edges, plain phase on leading
	assign rx_ev = cfg_reg.phase ? trail_ev : lead_ev;
	assign sh_ev = cfg_reg.phase ? lead_ev : trail_ev;
	assign din   = cfg_reg.master ? flt.miso : flt.mosi;

	// ==========================================================
	// Word loading
	// Master ends a plain-phase word at the last edge when phases match
	assign m_finish = (state_reg == ST_TRAIL && half_reg == '0)
	                  || (m_tick && edge_reg == LAST_EDGE && !cfg_reg.phase
	                      && long_len == short_len);
	assign m_load = cfg_reg.master && tx_valid
	                && ((state_reg == ST_IDLE) || m_finish);
	// Slave preloads after a full word so a following word starts in time
	assign s_load = !cfg_reg.master
	                && ((flt_reg.sel_n && !flt.sel_n && !loaded_reg)
	                    || (sh_ev && bit_cnt_reg == WORD_BITS));
	assign load    = m_load || s_load;
	assign pop     = load && tx_valid;
	assign tx_word = tx_valid ? tx_data : '0;

	// ==========================================================
	// Shift engine
	// Data moves out only on the edge opposite to sampling
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_sh_reg   <= '0;
			rx_sh_reg   <= '0;
			bit_cnt_reg <= '0;
			loaded_reg  <= 1'b0;
		end
		else if (load)
		begin
			tx_sh_reg   <= tx_word;
			bit_cnt_reg <= '0;
			loaded_reg  <= 1'b1;
		end
		else
		begin
			// First bit already sits on the line; later bits shift
			if (sh_ev && bit_cnt_reg != '0 && bit_cnt_reg != WORD_BITS)
				tx_sh_reg <= tx_sh_reg << 1;
			if (rx_ev && bit_cnt_reg != WORD_BITS)
			begin
				rx_sh_reg   <= {rx_sh_reg[WORD_W-2:0], din};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				loaded_reg  <= 1'b0;
			end
		end
	end

	// Received word; a new word beats a read clearing the flag
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_data_reg  <= '0;
			rx_valid_reg <= 1'b0;
			overrun_reg  <= 1'b0;
		end
		else
		begin
			if (acc && !pwrite && paddr == OFS_RXDATA)
				rx_valid_reg <= 1'b0;
			if (acc && pwrite && paddr == OFS_STATUS && pwdata[ST_OVR_BIT])
				overrun_reg <= 1'b0;
			if (rx_ev && bit_cnt_reg == LAST_BIT)
			begin
				rx_data_reg  <= {rx_sh_reg[WORD_W-2:0], din};
				rx_valid_reg <= 1'b1;
				if (rx_valid_reg)
					overrun_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Master sequencer
	// Trades a bit of idle gap for exact half-period select margins
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg    <= ST_IDLE;
			half_reg     <= '0;
			edge_reg     <= '0;
			sclk_reg     <= 1'b0;
			select_n_reg <= 1'b1;
		end
		else if (!cfg_reg.master)
		begin
			state_reg    <= ST_IDLE;
			sclk_reg     <= cfg_reg.polarity;
			select_n_reg <= 1'b1;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					sclk_reg <= cfg_reg.polarity;
					if (tx_valid)
					begin
						select_n_reg <= 1'b0;
						half_reg     <= long_len - 8'h01;
						edge_reg     <= '0;
						state_reg    <= ST_LEAD;
					end
				end
				ST_LEAD, ST_SHIFT:
				begin
					if (m_tick)
					begin
						sclk_reg  <= ~sclk_reg;
						edge_reg  <= edge_reg + 4'h1;
						state_reg <= ST_SHIFT;
						// Non-idle phase is the short one
						half_reg  <= (sclk_reg == cfg_reg.polarity) ?
						             short_len - 8'h01 : long_len - 8'h01;
						if (edge_reg == LAST_EDGE)
						begin
							state_reg <= ST_TRAIL;
							// Hold select half a period past the receiving edge
							half_reg  <= cfg_reg.phase ? long_len - 8'h01 :
							             long_len - short_len - 8'h01;
							if (m_finish)
								state_reg <= ST_IDLE;
						end
					end
					else
						half_reg <= half_reg - 8'h01;
				end
				ST_TRAIL:
				begin
					if (half_reg != '0)
						half_reg <= half_reg - 8'h01;
				end
			endcase
			// Next word waiting keeps select low
			if (m_finish)
			begin
				edge_reg <= '0;
				if (tx_valid)
				begin
					half_reg  <= long_len - 8'h01;
					state_reg <= ST_LEAD;
				end
				else
				begin
					select_n_reg <= 1'b1;
					state_reg    <= ST_IDLE;
				end
			end
		end
	end

	// Clock and select drive enables follow the role bit; master-in drives only as a selected slave
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_oe_reg <= 1'b0;
			sel_oe_reg  <= 1'b0;
			miso_oe_reg <= 1'b0;
		end
		else
		begin
			sclk_oe_reg <= cfg_reg.master;
			sel_oe_reg  <= cfg_reg.master;
			miso_oe_reg <= s_act;
		end
	end

	assign shift_clock_o      = sclk_reg;
	assign shift_clock_oe     = sclk_oe_reg;
	assign select_n_o         = select_n_reg;
	assign select_n_oe        = sel_oe_reg;
	assign master_out_line_o  = tx_sh_reg[WORD_W-1];
	assign master_out_line_oe = sclk_oe_reg;
	assign master_in_line_o   = tx_sh_reg[WORD_W-1];
	assign master_in_line_oe  = miso_oe_reg;

	// ==========================================================
	// Transmit FIFO
	scf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (push),
		.in_ready  (tx_in_ready),
		.in_data   (pwdata[WORD_W-1:0]),
		.out_valid (tx_valid),
		.out_ready (pop),
		.out_data  (tx_data)
	);

	// ==========================================================
	// APB slave
	// A data write to a full FIFO waits: pready stays low until room
	assign req   = psel && !pready_reg;
	assign tx_wr = pwrite && (paddr == OFS_TXDATA);
	assign acc   = psel && penable && pready_reg;
	assign push  = acc && tx_wr;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return a == OFS_CTRL || a == OFS_CFG || a == OFS_DIV
		       || a == OFS_TXDATA || a == OFS_RXDATA || a == OFS_STATUS;
	endfunction

	// Read data, unused bits zero
	always_comb
	begin
		rd_mux = '0;
		unique case (paddr)
			OFS_CTRL:
			begin
				rd_mux[CTRL_MASTER_BIT] = cfg_reg.master;
				rd_mux[CTRL_PHASE_BIT]  = cfg_reg.phase;
			end
			OFS_CFG:    rd_mux[CFG_POL_BIT] = cfg_reg.polarity;
			OFS_DIV:    rd_mux[DIV_W-1:0] = cfg_reg.divisor;
			OFS_RXDATA: rd_mux[WORD_W-1:0] = rx_data_reg;
			OFS_STATUS:
			begin
				rd_mux[ST_BUSY_BIT]  = (state_reg != ST_IDLE) || s_act;
				rd_mux[ST_FULL_BIT]  = !tx_in_ready;
				rd_mux[ST_EMPTY_BIT] = !tx_valid;
				rd_mux[ST_RXV_BIT]   = rx_valid_reg;
				rd_mux[ST_OVR_BIT]   = overrun_reg;
				rd_mux[ST_RATE_BIT]  = ratio_f(cfg_reg.divisor) < CNT_W'(MIN_RATIO_RX);
			end
			default:    rd_mux = '0;
		endcase
	end

	// Answer one cycle after setup, data and error taken then
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end
		else
		begin
			pready_reg  <= req && !(tx_wr && !tx_in_ready);
			pslverr_reg <= req && !is_mapped(paddr);
			if (req)
				prdata_reg <= pwrite ? '0 : rd_mux;
		end
	end

	// Control registers, written at the access edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cfg_reg <= CFG_RST;
		else if (acc && pwrite)
		begin
			if (paddr == OFS_CTRL)
			begin
				cfg_reg.master <= pwdata[CTRL_MASTER_BIT];
				cfg_reg.phase  <= pwdata[CTRL_PHASE_BIT];
			end
			if (paddr == OFS_CFG)
				cfg_reg.polarity <= pwdata[CFG_POL_BIT];
			if (paddr == OFS_DIV)
				cfg_reg.divisor <= pwdata[DIV_W-1:0];
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

	// ==========================================================
	// Assertions and their helper counters
	logic             sclk_q_reg;
	logic [CNT_W-1:0] lvl_cnt_reg, sel_low_reg, rcv_cnt_reg, lead_cnt_reg;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_q_reg   <= 1'b0;
			lvl_cnt_reg  <= '0;
			sel_low_reg  <= '0;
			rcv_cnt_reg  <= '0;
			lead_cnt_reg <= '0;
		end
		else
		begin
			sclk_q_reg   <= sclk_reg;
			lvl_cnt_reg  <= (sclk_reg != sclk_q_reg) ? 8'h01 : lvl_cnt_reg + 8'h01;
			sel_low_reg  <= select_n_reg ? '0 : sel_low_reg + 8'(sel_low_reg != 8'hff);
			rcv_cnt_reg  <= (m_tick && rx_ev) ? '0 : rcv_cnt_reg + 8'(rcv_cnt_reg != 8'hff);
			lead_cnt_reg <= m_lead ? '0 : lead_cnt_reg + 8'(lead_cnt_reg != 8'hff);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_release;
		cfg_reg.master && $stable(cfg_reg) && $rose(select_n_reg);
	endsequence

	a_master_drives_pins: assert property (
		cfg_reg.master && $past(cfg_reg.master) |-> shift_clock_oe && select_n_oe)
		else $error("master does not drive clock and select");
	a_slave_releases_clk: assert property (
		!cfg_reg.master && $past(!cfg_reg.master) |-> !shift_clock_oe && !master_out_line_oe)
		else $error("slave drives the clock or data line");
	a_plain_phase_edge: assert property (
		cfg_reg.master && !cfg_reg.phase && rx_ev |-> sclk_reg == cfg_reg.polarity)
		else $error("plain phase sampled on the wrong edge");
	a_idle_clock_level: assert property (
		cfg_reg.master && state_reg == ST_IDLE && $past(state_reg == ST_IDLE)
		&& $stable(cfg_reg) |-> sclk_reg == cfg_reg.polarity)
		else $error("idle clock level differs from polarity");
	a_idle_phase_len: assert property (
		$stable(cfg_reg) && state_reg == ST_SHIFT && sclk_reg != sclk_q_reg
		&& sclk_q_reg == cfg_reg.polarity && edge_reg > 4'h1 |-> lvl_cnt_reg == long_len)
		else $error("idle-level phase length wrong");
	a_active_phase_len: assert property (
		$stable(cfg_reg) && cfg_reg.master && $past(m_tick) && sclk_reg != sclk_q_reg
		&& sclk_q_reg != cfg_reg.polarity |-> lvl_cnt_reg == short_len)
		else $error("active-level phase length wrong");
	a_select_lead_time: assert property (
		$stable(cfg_reg) && m_tick && edge_reg == '0 |-> sel_low_reg >= long_len - 8'h01)
		else $error("select asserted too late before first edge");
	a_select_trail_time: assert property (
		s_release |-> rcv_cnt_reg == long_len)
		else $error("select released at wrong time after last receive");
	a_hold_select: assert property (
		s_release |-> !$past(tx_valid))
		else $error("select released while a word was waiting");
	a_delayed_setup: assert property (
		$stable(cfg_reg) && cfg_reg.phase && m_tick && rx_ev
		|-> lead_cnt_reg == short_len - 8'h01 ##1 $stable(master_out_line_o))
		else $error("delayed phase bit not set up half a period before sampling");
	a_opposite_edges: assert property (
		cfg_reg.master && state_reg == ST_SHIFT && $changed(master_out_line_o)
		|-> $past(sh_ev) && !$past(rx_ev))
		else $error("data changed on a sampling edge");
endmodule

// *** sim/scf_peer.sv ***
`timescale 1ns/1ps

// ==========================================================
// Far serial slave: answers one byte, collects what it hears
module scf_peer (
	// Link mode
	input  wire logic       pol,
	input  wire logic       phase,
	input  wire logic [7:0] reply,
	// Wire levels
	input  wire logic       sclk,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	// Answer and capture
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh = '0;

	initial miso = 1'b0;
	initial got = '0;

	// Load on select; phase 1 repeats the first bit on the first leading edge
	always @(negedge sel_n)
	begin
		sh = phase ? reply : {reply[6:0], 1'b0};
		miso = reply[7];
	end

	// A released line shows the inverse, never a stale level
	always @(posedge sel_n)
		miso = ~miso;

	// Sample on one edge, change on the other
	always @(sclk)
		if (!sel_n)
		begin
			if ((sclk != pol) != phase)
				got = {got[6:0], mosi};
			else
			begin
				miso = sh[7];
				sh = {sh[6:0], 1'b0};
			end
		end
endmodule

// *** sim/spi_master_clock_framing_tb.sv ***
`timescale 1ns/1ps

module spi_master_clock_framing_tb
	import scf_pkg::*;
;
	// ==========================================================
	// Bus, pins and far side
	logic              core_clk = 1'b0;
	logic              rst      = 1'b1;
	logic              psel     = 1'b0;
	logic              penable  = 1'b0;
	logic              pwrite   = 1'b0;
	logic [ADDR_W-1:0] paddr    = '0;
	logic [DATA_W-1:0] pwdata   = '0;
	logic [DATA_W-1:0] prdata;
	logic              pready, pslverr, sck_o, sck_oe, sel_o, sel_oe, mo_o, mo_oe, mi_o, mi_oe;
	logic              sclk_in = 1'b0, sel_in = 1'b1, mosi_in = 1'b0, pol = 1'b0, ph = 1'b0;
	logic              miso_p;
	logic [7:0]        reply = '0, got;
	int                failures = 0, n_compared = 0;
	wire               sclk_w = sck_oe ? sck_o : sclk_in;
	wire               sel_w  = sel_oe ? sel_o : sel_in;
	wire               mo_w   = mo_oe ? mo_o : mosi_in;
	wire               mi_w   = mi_oe ? mi_o : miso_p;

	always #25 core_clk = ~core_clk;

	scf_spi_top DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shift_clock_i(sclk_w), .shift_clock_o(sck_o),
		.shift_clock_oe(sck_oe), .select_n_i(sel_w), .select_n_o(sel_o), .select_n_oe(sel_oe),
		.master_out_line_i(mo_w), .master_out_line_o(mo_o), .master_out_line_oe(mo_oe),
		.master_in_line_i(mi_w), .master_in_line_o(mi_o), .master_in_line_oe(mi_oe));

	scf_peer peer (.pol(pol), .phase(ph), .reply(reply), .sclk(sclk_w), .sel_n(sel_w),
		.mosi(mo_w), .miso(miso_p), .got(got));

	// ==========================================================
	// Reporting and bus tasks
	task automatic end_of_test();
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 2000);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
		if (n >= 2000)
		begin
			failures++;
			end_of_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, '0, r, e);
	endtask

	// Cycles until a pin shows a level; which 0 = shift clock, 1 = select
	task automatic wait_for(input bit which, input logic lvl, output int n);
		n = 0;
		while ((which ? sel_o : sck_o) !== lvl && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000)
		begin
			failures++;
			end_of_test();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic regs();
		logic [31:0] r;
		logic e;
		rd(OFS_CTRL, r);
		chk(r, 32'h0);
		chk({sel_o, sel_oe, sck_oe, mi_oe}, 4'b1000);
		wr(OFS_DIV, 32'h55);
		rd(OFS_DIV, r);
		chk(r, 32'h55);
		apb(1'b0, 8'h40, '0, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0);
	endtask

	// Framing, phase lengths and sent data for one master word; received data too above divisor 6
	task automatic master_word(input logic p, input logic h, input logic [6:0] dv,
		input logic [7:0] d, input logic [7:0] rp);
		int r, s, lead, hi, lo, n;
		logic [31:0] x;
		r = (dv < 3) ? 4 : int'(dv) + 1;
		s = r / 2;
		pol = p;
		ph = h;
		reply = rp;
		wr(OFS_CFG, 32'(p) << CFG_POL_BIT);
		wr(OFS_DIV, 32'(dv));
		wr(OFS_CTRL, (32'h1 << CTRL_MASTER_BIT) | (32'(h) << CTRL_PHASE_BIT));
		// Drive enables follow the role bit one edge later
		@(posedge core_clk);
		chk(sck_o, p);
		chk({sel_o, sel_oe, sck_oe, mi_oe}, 4'b1110);
		wr(OFS_TXDATA, 32'(d));
		wait_for(1'b1, 1'b0, n);
		wait_for(1'b0, ~p, lead);
		chk(lead, r - s);
		wait_for(1'b0, p, hi);
		wait_for(1'b0, ~p, lo);
		chk(hi, s);
		chk(hi + lo, r);
		wait_for(1'b1, 1'b1, n);
		chk(got, d);
		rd(OFS_RXDATA, x);
		if (dv > 6)
			chk(x, 32'(rp));
	endtask

	// Six queued words: queue fills and writes wait, select stays low throughout
	task automatic back_to_back();
		int n;
		logic [31:0] x;
		wr(OFS_DIV, 32'h7);
		for (int i = 0; i < 6; i++)
		begin
			wr(OFS_TXDATA, 32'h30 + i);
			if (i == 4)
			begin
				rd(OFS_STATUS, x);
				chk(x[ST_FULL_BIT], 1'b1);
			end
		end
		wait_for(1'b1, 1'b0, n);
		wait_for(1'b1, 1'b1, n);
		chk(n >= 256, 1'b1);
		chk(got, 8'h35);
	endtask

	// Far master at 400 ns clocks one word in and the queued word out
	task automatic slave_word(input logic [7:0] d, input logic [7:0] tx);
		logic [7:0] q;
		logic [31:0] x;
		q = '0;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CFG, 32'h0);
		chk({sel_oe, sck_oe, mo_oe}, 3'b000);
		rd(OFS_RXDATA, x);
		wr(OFS_TXDATA, 32'(tx));
		sel_in <= 1'b0;
		mosi_in <= d[7];
		repeat (4) @(posedge core_clk);
		for (int i = 7; i >= 0; i--)
		begin
			repeat (4) @(posedge core_clk);
			sclk_in <= 1'b1;
			chk(mi_oe, 1'b1);
			repeat (4) @(posedge core_clk);
			// Slave output lags the pin by its synchroniser: take it at the phase end
			q = {q[6:0], mi_o};
			sclk_in <= 1'b0;
			if (i > 0)
				mosi_in <= d[i-1];
		end
		repeat (4) @(posedge core_clk);
		sel_in <= 1'b1;
		mosi_in <= ~mosi_in;
		repeat (8) @(posedge core_clk);
		chk(q, tx);
		rd(OFS_RXDATA, x);
		chk(x, 32'(d));
	endtask

	// ==========================================================
	// Main sequence and hang guard
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		regs();
		master_word(1'b0, 1'b0, 7'd7, 8'ha5, 8'h5a);
		master_word(1'b1, 1'b0, 7'd8, 8'h96, 8'h3c);
		master_word(1'b0, 1'b1, 7'd8, 8'h81, 8'he7);
		master_word(1'b1, 1'b1, 7'd7, 8'h4b, 8'hd2);
		master_word(1'b0, 1'b0, 7'd2, 8'h6e, 8'h00);
		back_to_back();
		slave_word(8'hb4, 8'h2d);
		end_of_test();
	end

	initial
	begin
		#2_000_000;
		failures++;
		end_of_test();
	end
endmodule
